// ---- core/nsc_switch_decoder.sv ----
`timescale 1ns/100ps
`include "nsc_defines.svh"

// Behaviour
// - Station bank is binary node identifier, bit0=switch1.
// - Address is fixed prefix plus node identifier.
// - Bus error: clear outputs, or hold when switch1.
// - Fault bank switches 2 to 8 ignored.
// - All switches default OFF; identifier zero invalid.
// - Manifold holds at most ten units.
// - Out-of-range identifier flashes the error indicator.
module nsc_switch_decoder #(
    parameter int unsigned SETTLE_CYC = `NSC_SETTLE_CYC,
    parameter int unsigned FLASH_CYC = `NSC_FLASH_CYC
) (
    input wire logic core_clk,                 // 200 MHz system clock.
    input wire logic nrst,                     // Asynchronous reset, active low.
    input wire logic [7:0] faultActionSwitch,  // Fault action bank, ON is one.
    input wire logic [7:0] stationSwitch,      // Station number bank, ON is one.
    input wire logic busCommError,             // Fieldbus error, same domain.
    input wire logic [7:0] outCommand,         // Output image from the master.
    input wire logic [3:0] unitCount,          // Units found on the manifold.
    output nsc_pkg::nsc_cfg_t cfg,             // Decoded configuration.
    output logic cfgReady,                     // Configuration latched.
    output logic [7:0] outDrive,               // Outputs to the drivers.
    output logic busErrorIndicator,            // Red error lamp drive.
    output logic unitOverflow                  // Too many units fitted.
);

    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    // Three stages; a switch value is trusted once stages two and three agree.
    logic [7:0] faultS1, faultS2, faultS3;     // Fault bank pipeline.
    logic [7:0] stationS1, stationS2, stationS3; // Station bank pipeline.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            faultS1 <= 8'h00;
            faultS2 <= 8'h00;
            faultS3 <= 8'h00;
            stationS1 <= 8'h00;
            stationS2 <= 8'h00;
            stationS3 <= 8'h00;
        end else begin
            faultS1 <= faultActionSwitch;
            faultS2 <= faultS1;
            faultS3 <= faultS2;
            stationS1 <= stationSwitch;
            stationS2 <= stationS1;
            stationS3 <= stationS2;
        end
    end

    // Both banks stable means stages two and three agree on every bit.
    wire banksStable = (faultS2 == faultS3) && (stationS2 == stationS3);

    // -------------------------------------------------------------
    // Power-up sequencer
    // -------------------------------------------------------------
    nsc_pkg::nsc_state_t state;      // Sequence state.
    nsc_pkg::nsc_state_t next_state; // Next sequence state.
    logic [31:0] settleCount;        // Cycles waited after reset.
    // SETTLE_CYC must be two or more: below that the pipeline still holds
    // reset zeros, and stages two and three would agree on a false value.
    wire settleDone = (settleCount >= SETTLE_CYC - 1);

    // Wait for the settle time, then capture on a stable sample, then run.
    always_comb begin
        next_state = state;
        unique case (state)
            nsc_pkg::NSC_SETTLE: begin
                if (settleDone) begin
                    next_state = nsc_pkg::NSC_CAPTURE;
                end
            end
            nsc_pkg::NSC_CAPTURE: begin
                if (banksStable) begin
                    next_state = nsc_pkg::NSC_RUN;
                end
            end
            nsc_pkg::NSC_RUN: begin
                next_state = nsc_pkg::NSC_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= nsc_pkg::NSC_SETTLE;
            settleCount <= 32'h0000_0000;
        end else begin
            state <= next_state;
            if (!settleDone) begin
                settleCount <= settleCount + 32'h0000_0001;
            end
        end
    end

    wire captureNow = (state == nsc_pkg::NSC_CAPTURE) && banksStable;

    // -------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------
    // Only switch one of the fault bank is looked at; the rest are reserved.
    wire holdSel = faultS3[`NSC_HOLD_BIT];
    wire [7:0] nodeSel = stationS3;
    wire nodeOk = (nodeSel >= `NSC_NODE_MIN) && (nodeSel <= `NSC_NODE_MAX);
    wire [31:0] ipSel = {`NSC_IP_OCT0, `NSC_IP_OCT1, `NSC_IP_OCT2, nodeSel};

    // The captured image never follows the switches again; a reset through nrst is needed.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= '0;
            cfgReady <= 1'b0;
        end else if (captureNow) begin
            cfg.holdOnFault <= holdSel;
            cfg.nodeId <= nodeSel;
            cfg.nodeValid <= nodeOk;
            cfg.ipAddr <= ipSel;
            cfgReady <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Output fault action
    // -------------------------------------------------------------
    // Until the configuration is known, outputs stay off as the safe choice.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            outDrive <= 8'h00;
        end else if (!cfgReady) begin
            outDrive <= 8'h00;
        end else if (busCommError) begin
            if (!cfg.holdOnFault) begin
                outDrive <= 8'h00;
            end
        end else begin
            outDrive <= outCommand;
        end
    end

    // -------------------------------------------------------------
    // Manifold population check
    // -------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            unitOverflow <= 1'b0;
        end else begin
            unitOverflow <= (unitCount > `NSC_MAX_UNITS);
        end
    end

    // -------------------------------------------------------------
    // Error indicator
    // -------------------------------------------------------------
    logic flashWave; // Flashing level from the generator.
    wire flashOn = cfgReady && !cfg.nodeValid;

    nsc_flasher #(
        .HALF_CYC(FLASH_CYC)
    ) u_flasher (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(flashOn),
        .wave(flashWave)
    );

    // Registered so the lamp output comes from a flip-flop; a bus error
    // lights it steadily when the identifier itself is legal.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busErrorIndicator <= 1'b0;
        end else if (flashOn) begin
            busErrorIndicator <= flashWave;
        end else begin
            busErrorIndicator <= cfgReady && busCommError;
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    a_clear_on_fault: assert property (@(posedge core_clk) disable iff (!nrst)
        (cfgReady && busCommError && !cfg.holdOnFault) |=> (outDrive == 8'h00))
        else $error("Outputs not cleared on bus error.");

    a_hold_on_fault: assert property (@(posedge core_clk) disable iff (!nrst)
        (cfgReady && busCommError && cfg.holdOnFault) |=> $stable(outDrive))
        else $error("Outputs not held on bus error.");

    a_ip_prefix: assert property (@(posedge core_clk) disable iff (!nrst)
        cfgReady |-> (cfg.ipAddr == {`NSC_IP_OCT0, `NSC_IP_OCT1, `NSC_IP_OCT2, cfg.nodeId}))
        else $error("Address prefix or last octet wrong.");

    a_node_range: assert property (@(posedge core_clk) disable iff (!nrst)
        cfgReady |-> (cfg.nodeValid == (cfg.nodeId != 8'h00 && cfg.nodeId < 8'hF0)))
        else $error("Node range flag wrong.");

    a_node_decode: assert property (@(posedge core_clk) disable iff (!nrst)
        captureNow |=> (cfg.nodeId == $past(stationS3)))
        else $error("Node identifier not taken from station bank.");

    a_reserved_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
        captureNow |=> (cfg.holdOnFault == $past(faultS3[0])))
        else $error("Fault action not taken from switch one.");

    a_latch_once: assert property (@(posedge core_clk) disable iff (!nrst)
        cfgReady |=> (cfgReady && $stable(cfg)))
        else $error("Configuration changed after capture.");

    a_lamp_off_valid: assert property (@(posedge core_clk) disable iff (!nrst)
        (cfgReady && cfg.nodeValid && !busCommError) |=> !busErrorIndicator)
        else $error("Indicator lit with valid node and no error.");

    a_outputs_safe_early: assert property (@(posedge core_clk) disable iff (!nrst)
        (!cfgReady) |=> (outDrive == 8'h00))
        else $error("Outputs driven before configuration was latched.");

    a_unit_limit: assert property (@(posedge core_clk) disable iff (!nrst)
        (unitCount <= 4'hA) [*2] |-> !unitOverflow)
        else $error("Overflow flagged for ten units or fewer.");

endmodule : nsc_switch_decoder

// ---- core/nsc_defines.svh ----
`ifndef NSC_DEFINES_SVH
`define NSC_DEFINES_SVH

// Switch bank geometry and field positions.
`define NSC_SW_WIDTH 4'h8
`define NSC_HOLD_BIT 0
`define NSC_NODE_MIN 8'h01
`define NSC_NODE_MAX 8'hEF
// Fixed address prefix octets.
`define NSC_IP_OCT0 8'hC0
`define NSC_IP_OCT1 8'hA8
`define NSC_IP_OCT2 8'h64
// Manifold population limit.
`define NSC_MAX_UNITS 4'hA
// Power-up settle time before sampling switches, in ns, and derived cycles.
`define NSC_SETTLE_NS 1000
`define NSC_CLK_NS 5
`define NSC_SETTLE_CYC ((`NSC_SETTLE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
// Error indicator flash half period in ns (250 ms), and derived cycles.
`define NSC_FLASH_NS 250000000
`define NSC_FLASH_CYC (`NSC_FLASH_NS / `NSC_CLK_NS)
// Reset values.
`define NSC_NODE_RST 8'h00

`endif

// ---- core/nsc_pkg.sv ----
package nsc_pkg;

    // Decoded configuration as handed to the fieldbus side.
    typedef struct packed {
        logic holdOnFault;    // One keeps outputs on a bus fault.
        logic [7:0] nodeId;   // Node identifier from the station bank.
        logic nodeValid;      // Node identifier lies in the legal range.
        logic [31:0] ipAddr;  // Full address, prefix then node identifier.
    } nsc_cfg_t;

    // Power-up sampling sequence.
    typedef enum logic [1:0] {
        NSC_SETTLE,
        NSC_CAPTURE,
        NSC_RUN
    } nsc_state_t;

endpackage : nsc_pkg

// ---- core/nsc_flasher.sv ----
`timescale 1ns/100ps
`include "nsc_defines.svh"

// Square wave generator for the error indicator; runs only while enabled.
module nsc_flasher #(
    parameter int unsigned HALF_CYC = `NSC_FLASH_CYC
) (
    input wire logic core_clk, // System clock.
    input wire logic nrst,     // Asynchronous reset, active low.
    input wire logic enable,   // Flash while high.
    output logic wave          // Flashing level, low when disabled.
);

    logic [31:0] count; // Cycles spent in the current half period.

    // -------------------------------------------------------------
    // Half period counter
    // -------------------------------------------------------------
    // Restarting from zero on disable makes the first phase, which is dark, full length.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0000_0000;
            wave <= 1'b0;
        end else if (!enable) begin
            count <= 32'h0000_0000;
            wave <= 1'b0;
        end else if (count >= HALF_CYC - 1) begin
            count <= 32'h0000_0000;
            wave <= ~wave;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

endmodule : nsc_flasher

// ---- tb/nsc_field_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Switch banks and fieldbus master seen from outside the unit.
// ----------------------------------------------------------------
// Switches are plain levels, so the model only hands the bench's choice on.
module nsc_field_model (
    input wire logic [7:0] faSet,           // Wanted fault bank positions.
    input wire logic [7:0] stSet,           // Wanted station bank positions.
    input wire logic errSet,                // Wanted bus fault level.
    input wire logic [7:0] cmdSet,          // Wanted output image.
    output logic [7:0] faultActionSwitch,   // Fault bank, ON is one.
    output logic [7:0] stationSwitch,       // Station bank, ON is one.
    output logic busCommError,              // Fieldbus fault level.
    output logic [7:0] outCommand           // Output image from the master.
);
    // The master may raise a fault or send an image at any cycle.
    assign faultActionSwitch = faSet;
    assign stationSwitch = stSet;
    assign busCommError = errSet;
    assign outCommand = cmdSet;
endmodule : nsc_field_model

// ---- tb/tb_node_switch_config_decoder.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bench for the switch decoder, with short settle and flash counts.
// ----------------------------------------------------------------
module tb_node_switch_config_decoder;
    logic core_clk = 1'b0; // 200 MHz clock.
    logic nrst = 1'b0; // Reset, active low.
    logic [7:0] faSet = 8'h00; // All switches start OFF.
    logic [7:0] stSet = 8'h00; // Station bank setting.
    logic errSet = 1'b0; // Bus fault level.
    logic [7:0] cmdSet = 8'h00; // Output image.
    logic [3:0] unitCount = 4'h1; // Units fitted.
    logic [7:0] faultActionSwitch, stationSwitch, outCommand, outDrive; // Wires.
    logic busCommError, cfgReady, busErrorIndicator, unitOverflow; // Wires.
    nsc_pkg::nsc_cfg_t cfg; // Decoded configuration.
    int error_cnt = 0; // Mismatches.
    int checks = 0; // Comparisons.
    int cycles = 0; // Timeout counter.

    nsc_field_model PEER (.faSet(faSet), .stSet(stSet), .errSet(errSet), .cmdSet(cmdSet),
        .faultActionSwitch(faultActionSwitch), .stationSwitch(stationSwitch),
        .busCommError(busCommError), .outCommand(outCommand));
    nsc_switch_decoder #(.SETTLE_CYC(4), .FLASH_CYC(4)) DUT (.core_clk(core_clk),
        .nrst(nrst), .faultActionSwitch(faultActionSwitch), .stationSwitch(stationSwitch),
        .busCommError(busCommError), .outCommand(outCommand), .unitCount(unitCount),
        .cfg(cfg), .cfgReady(cfgReady), .outDrive(outDrive),
        .busErrorIndicator(busErrorIndicator), .unitOverflow(unitOverflow));

    // Free running clock.
    initial forever #2.5 core_clk = ~core_clk;

    // A hang is cut short well past the longest expected run.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Compares four-state values, so an unknown never matches.
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Resets with given switches and waits, bounded, for the capture.
    task automatic power_up(logic [7:0] fa, logic [7:0] st);
        @(negedge core_clk);
        nrst = 1'b0;
        faSet = fa;
        stSet = st;
        errSet = 1'b0;
        cmdSet = 8'h5A;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        check("early outDrive", outDrive, 8'h00);
        for (int i = 0; i < 40 && cfgReady !== 1'b1; i++) @(negedge core_clk);
        check("cfgReady", cfgReady, 1'b1);
    endtask : power_up

    // Boundary and out-of-range station numbers.
    task automatic test_decode();
        logic [7:0] vals [6] = '{8'h01, 8'h02, 8'hEF, 8'hF0, 8'h00, 8'hFF};
        foreach (vals[i]) begin
            power_up(8'h00, vals[i]);
            check("nodeId", cfg.nodeId, vals[i]);
            check("nodeValid", cfg.nodeValid, vals[i] >= 8'h01 && vals[i] <= 8'hEF);
            check("ipAddr", cfg.ipAddr, {8'hC0, 8'hA8, 8'h64, vals[i]});
            check("holdOnFault", cfg.holdOnFault, 1'b0);
        end
    endtask : test_decode

    // Bus fault with the hold switch off or on; reserved switches set when hold is off.
    task automatic test_fault(logic [7:0] fa, logic hold);
        power_up(fa, 8'h05);
        cmdSet = 8'h3C;
        @(negedge core_clk);
        check("outDrive run", outDrive, 8'h3C);
        errSet = 1'b1;
        cmdSet = 8'hC3;
        @(negedge core_clk);
        check("outDrive fault", outDrive, hold ? 8'h3C : 8'h00);
        check("lamp on", busErrorIndicator, 1'b1);
        errSet = 1'b0;
        @(negedge core_clk);
        check("outDrive back", outDrive, 8'hC3);
        check("lamp off", busErrorIndicator, 1'b0);
    endtask : test_fault

    // Switch moves while running must not reach the decoded values.
    task automatic test_latch();
        power_up(8'h01, 8'h05);
        faSet = 8'h00;
        stSet = 8'hEF;
        repeat (6) @(negedge core_clk);
        check("latched node", cfg.nodeId, 8'h05);
        check("latched hold", cfg.holdOnFault, 1'b1);
    endtask : test_latch

    // Node zero is invalid, so the lamp must flash by itself.
    task automatic test_flash();
        int rises = 0;
        logic last;
        power_up(8'h00, 8'h00);
        last = busErrorIndicator;
        repeat (20) begin
            @(negedge core_clk);
            if (busErrorIndicator === 1'b1 && last === 1'b0) rises++;
            last = busErrorIndicator;
        end
        check("flash rises", rises, 2);
    endtask : test_flash

    // Ten units is the limit; eleven is too many.
    task automatic test_units();
        unitCount = 4'hA;
        repeat (2) @(negedge core_clk);
        check("ten units", unitOverflow, 1'b0);
        unitCount = 4'hB;
        repeat (2) @(negedge core_clk);
        check("eleven units", unitOverflow, 1'b1);
    endtask : test_units

    // Single place where the run ends.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        test_decode();
        test_fault(8'hFE, 1'b0);
        test_fault(8'h01, 1'b1);
        test_latch();
        test_flash();
        test_units();
        tally_and_finish();
    end
endmodule : tb_node_switch_config_decoder
